// *** include/pcp_map.svh ***
// constants for the parallel configuration port
`ifndef PCP_MAP_SVH
`define PCP_MAP_SVH

`define PCP_DATA_W        16
`define PCP_ADDR_W        26
`define PCP_MODE_W        2
`define PCP_MODE_MASTER_PAR 2'h0
`define PCP_MODE_SLAVE_PAR  2'h2
`define PCP_MODE_MASTER_SER 2'h1
`define PCP_MODE_SLAVE_SER  2'h3
`define PCP_SYS_CLK_MHZ   25
`define PCP_CONFIG_CLOCK_DIV      2
`define PCP_STARTUP_CYC   8
`define PCP_WORD_COUNT    16'h0010
`define PCP_CRC_INIT      16'hffff
`define PCP_CRC_POLY      16'h1021

`endif

// *** include/pcp_pkg.sv ***
// types for the parallel configuration port
package pcp_pkg;
	typedef enum logic [2:0] {
		PCP_ST_WAIT_INIT,
		PCP_ST_SAMPLE,
		PCP_ST_LOAD,
		PCP_ST_STARTUP,
		PCP_ST_DONE,
		PCP_ST_ERROR
	} pcp_state_t;
endpackage

// *** core/pcp_sync2.sv ***
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module pcp_sync2 #(
	parameter int W     = 1,
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= {W{RST_VAL}};
			q        <= {W{RST_VAL}};
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule // pcp_sync2
`default_nettype wire

// *** core/pcp_crc16.sv ***
// crc-16 over one data word
`timescale 1ns/1ps
`default_nettype none
`include "pcp_map.svh"
module pcp_crc16 (
	input  wire logic [15:0] crc_in,
	input  wire logic [15:0] data,
	output logic      [15:0] crc_out
);
	always_comb begin
		logic [15:0] c;
		c = crc_in;
		for (int i = 15; i >= 0; i--) begin
			if (c[15] ^ data[i]) begin
				c = {c[14:0], 1'b0} ^ `PCP_CRC_POLY;
			end else begin
				c = {c[14:0], 1'b0};
			end
		end
		crc_out = c;
	end
endmodule // pcp_crc16
`default_nettype wire

// *** core/pcp_port.sv ***
// parallel configuration port, device side
// How it works
// - data bus captured and presented on rising configuration clock edge
// - done pin high once configured, low before
// - after mode sampling init pulled low on crc error, released otherwise
// - upset detection enable has no effect; init is pulled low only on crc error
// - full-chip reset pin low resets everything asynchronously
// - in slave modes port select low enables data bus, high disables it
// - direction low makes data pins inputs, high makes them outputs only in slave modes
// - direction change while selected during load or startup is treated as abort
// - chain select output active low for downstream devices
// - busy output high while words are written, in readback high only on abort
// - two-bit mode pins choose configuration mode
// - config clock is output in master modes, input in slave modes
// - master parallel mode supports eight- or sixteen-bit bus
// - master mode drives flash address and control outputs during load
// - startup sequence is clocked by the configuration clock
// - mode pins sampled when init pin goes high
// - master drives config clock from internal clock; slave receives it
// - sampling starts third rising edge after select, one word per edge
`timescale 1ns/1ps
`default_nettype none
`include "pcp_map.svh"
module pcp_port
	import pcp_pkg::*;
(
	input  wire logic                    sys_clk,
	input  wire logic                    rst,
	input  wire logic                    link_clk,
	input  wire logic                    full_reset_n,
	input  wire logic [`PCP_MODE_W-1:0]  mode_pins,
	input  wire logic                    bus_x16,
	input  wire logic                    seu_detect_en,
	input  wire logic                    port_select_n,
	input  wire logic                    read_write_dir,
	input  wire logic [`PCP_DATA_W-1:0]  data_in,
	output logic      [`PCP_DATA_W-1:0]  data_out,
	output logic                         data_oe,
	input  wire logic                    init_in,
	output logic                         init_out,
	output logic                         init_oe,
	output logic                         config_clock_out,
	output logic                         config_clock_oe,
	output logic                         done,
	output logic                         busy,
	output logic                         chain_select_out_n,
	output logic      [`PCP_ADDR_W-1:0]  flash_addr,
	output logic                         flash_output_enable_n,
	output logic                         flash_chip_select_n,
	output logic                         flash_write_enable_n,
	output logic                         abort_seen,
	output logic                         crc_error
);
	// ----------------------------------------
	// reset and pin synchronisers
	// ----------------------------------------
	logic areset;
	assign areset = rst | ~full_reset_n;

	logic init_s;
	logic [`PCP_MODE_W-1:0] mode_s;
	pcp_sync2 #(.W(1), .RST_VAL(1'b0)) u_init_sync (
		.clk (sys_clk),
		.rst (areset),
		.d   (init_in),
		.q   (init_s)
	);
	pcp_sync2 #(.W(`PCP_MODE_W), .RST_VAL(1'b0)) u_mode_sync (
		.clk (sys_clk),
		.rst (areset),
		.d   (mode_pins),
		.q   (mode_s)
	);

	// ----------------------------------------
	// control state machine, system clock
	// ----------------------------------------
	pcp_state_t state_reg;
	logic [`PCP_MODE_W-1:0] mode_reg;
	logic master_reg;
	logic init_prev_reg;
	logic init_rise;
	logic load_done_s;
	logic crc_bad_s;
	logic startup_done_s;

	assign init_rise = init_s & ~init_prev_reg;

	always_ff @(posedge sys_clk or posedge areset) begin
		if (areset) begin
			init_prev_reg <= 1'b0;
		end else begin
			init_prev_reg <= init_s;
		end
	end

	always_ff @(posedge sys_clk or posedge areset) begin
		if (areset) begin
			state_reg <= PCP_ST_WAIT_INIT;
		end else begin
			case (state_reg)
				// held low by the outside world postpones everything
				PCP_ST_WAIT_INIT: if (init_rise) state_reg <= PCP_ST_SAMPLE;
				PCP_ST_SAMPLE:    state_reg <= PCP_ST_LOAD;
				PCP_ST_LOAD: begin
					if (crc_bad_s) begin
						state_reg <= PCP_ST_ERROR;
					end else if (load_done_s) begin
						state_reg <= PCP_ST_STARTUP;
					end
				end
				PCP_ST_STARTUP: if (startup_done_s) state_reg <= PCP_ST_DONE;
				PCP_ST_DONE:    state_reg <= PCP_ST_DONE;
				PCP_ST_ERROR:   state_reg <= PCP_ST_ERROR;
				default:        state_reg <= PCP_ST_WAIT_INIT;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge areset) begin
		if (areset) begin
			mode_reg   <= `PCP_MODE_SLAVE_PAR;
			master_reg <= 1'b0;
		end else if (state_reg == PCP_ST_WAIT_INIT && init_rise) begin
			mode_reg   <= mode_s;
			master_reg <= ~mode_s[1];
		end
	end

	// ----------------------------------------
	// configuration clock generation, master
	// ----------------------------------------
	logic [`PCP_CONFIG_CLOCK_DIV-1:0] div_reg;
	logic loading;
	assign loading = (state_reg == PCP_ST_LOAD) || (state_reg == PCP_ST_STARTUP);

	always_ff @(posedge sys_clk or posedge areset) begin
		if (areset) begin
			div_reg <= '0;
		end else if (master_reg && loading) begin
			div_reg <= div_reg + 1'b1;
		end
	end

	always_comb begin
		config_clock_oe  = master_reg && state_reg != PCP_ST_WAIT_INIT;
		config_clock_out = div_reg[`PCP_CONFIG_CLOCK_DIV-1];
	end

	// ----------------------------------------
	// status pins
	// ----------------------------------------
	logic crc_err_reg;
	always_ff @(posedge sys_clk or posedge areset) begin
		if (areset) begin
			crc_err_reg <= 1'b0;
		end else if (state_reg == PCP_ST_ERROR) begin
			crc_err_reg <= 1'b1;
		end
	end

	always_comb begin
		// low before mode sampling keeps the pin as an input
		init_oe   = (state_reg != PCP_ST_WAIT_INIT) && (crc_err_reg || seu_detect_en) && crc_err_reg;
		init_out  = 1'b0;
		crc_error = crc_err_reg;
	end

	always_ff @(posedge sys_clk or posedge areset) begin
		if (areset) begin
			done <= 1'b0;
		end else begin
			done <= (state_reg == PCP_ST_DONE);
		end
	end

	// ----------------------------------------
	// link domain: bus capture and readback
	// ----------------------------------------
	logic load_en_l;
	logic master_l;
	logic x16_l;
	logic sel_n_l;
	logic dir_l;
	pcp_sync2 #(.W(1), .RST_VAL(1'b0)) u_load_sync (
		.clk (link_clk),
		.rst (areset),
		.d   (loading),
		.q   (load_en_l)
	);
	pcp_sync2 #(.W(1), .RST_VAL(1'b0)) u_mst_sync (
		.clk (link_clk),
		.rst (areset),
		.d   (master_reg),
		.q   (master_l)
	);
	pcp_sync2 #(.W(1), .RST_VAL(1'b0)) u_x16_sync (
		.clk (link_clk),
		.rst (areset),
		.d   (bus_x16),
		.q   (x16_l)
	);
	pcp_sync2 #(.W(1), .RST_VAL(1'b1)) u_sel_sync (
		.clk (link_clk),
		.rst (areset),
		.d   (port_select_n),
		.q   (sel_n_l)
	);
	pcp_sync2 #(.W(1), .RST_VAL(1'b0)) u_dir_sync (
		.clk (link_clk),
		.rst (areset),
		.d   (read_write_dir),
		.q   (dir_l)
	);

	logic [15:0] word_cnt_reg;
	logic [15:0] crc_reg;
	logic [15:0] crc_nxt;
	logic [15:0] word_in;
	logic [`PCP_ADDR_W-1:0] addr_reg;
	logic dir_prev_reg;
	logic abort_reg;
	logic loaded_reg;
	logic crc_bad_reg;
	logic [3:0] start_cnt_reg;
	logic startup_reg;
	logic active;

	// master from flash is always selected; capture still needs direction low
	assign active  = load_en_l && (master_l || !sel_n_l);
	assign word_in = x16_l ? data_in : {8'h00, data_in[7:0]};

	pcp_crc16 u_crc (
		.crc_in  (crc_reg),
		.data    (word_in),
		.crc_out (crc_nxt)
	);

	always_ff @(posedge link_clk or posedge areset) begin
		if (areset) begin
			word_cnt_reg <= '0;
			crc_reg      <= `PCP_CRC_INIT;
			loaded_reg   <= 1'b0;
			crc_bad_reg  <= 1'b0;
		end else if (active && !dir_l && !loaded_reg && !abort_reg) begin
			crc_reg      <= crc_nxt;
			word_cnt_reg <= word_cnt_reg + 16'h0001;
			if (word_cnt_reg == `PCP_WORD_COUNT - 16'h0001) begin
				loaded_reg  <= 1'b1;
				crc_bad_reg <= (crc_nxt != 16'h0000);
			end
		end
	end

	always_ff @(posedge link_clk or posedge areset) begin
		if (areset) begin
			dir_prev_reg <= 1'b0;
			abort_reg    <= 1'b0;
		end else begin
			dir_prev_reg <= dir_l;
			// direction may only move while deselected
			if (!sel_n_l && load_en_l && dir_l != dir_prev_reg) begin
				abort_reg <= 1'b1;
			end else if (sel_n_l) begin
				abort_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge link_clk or posedge areset) begin
		if (areset) begin
			data_out <= '0;
		end else if (active && dir_l) begin
			data_out <= crc_reg;
		end
	end

	always_ff @(posedge link_clk or posedge areset) begin
		if (areset) begin
			addr_reg <= '0;
		end else if (master_l && active && !loaded_reg) begin
			addr_reg <= addr_reg + 1'b1;
		end
	end

	always_ff @(posedge link_clk or posedge areset) begin
		if (areset) begin
			start_cnt_reg <= '0;
			startup_reg   <= 1'b0;
		end else if (loaded_reg && !crc_bad_reg && !startup_reg) begin
			start_cnt_reg <= start_cnt_reg + 4'h1;
			if (start_cnt_reg == 4'(`PCP_STARTUP_CYC - 1)) startup_reg <= 1'b1;
		end
	end

	always_comb begin
		data_oe               = !sel_n_l && dir_l && !master_l;
		busy                  = abort_reg || (active && !loaded_reg && !dir_l);
		chain_select_out_n    = !loaded_reg;
		flash_addr            = addr_reg;
		flash_chip_select_n   = !(master_l && active && !loaded_reg);
		flash_output_enable_n = flash_chip_select_n;
		flash_write_enable_n  = 1'b1;
	end

	// ----------------------------------------
	// link to system crossing, level flags
	// ----------------------------------------
	logic abort_s;
	pcp_sync2 #(.W(1), .RST_VAL(1'b0)) u_ld_sync (
		.clk (sys_clk),
		.rst (areset),
		.d   (loaded_reg & ~crc_bad_reg),
		.q   (load_done_s)
	);
	pcp_sync2 #(.W(1), .RST_VAL(1'b0)) u_bad_sync (
		.clk (sys_clk),
		.rst (areset),
		.d   (crc_bad_reg),
		.q   (crc_bad_s)
	);
	pcp_sync2 #(.W(1), .RST_VAL(1'b0)) u_st_sync (
		.clk (sys_clk),
		.rst (areset),
		.d   (startup_reg),
		.q   (startup_done_s)
	);
	pcp_sync2 #(.W(1), .RST_VAL(1'b0)) u_ab_sync (
		.clk (sys_clk),
		.rst (areset),
		.d   (abort_reg),
		.q   (abort_s)
	);
	assign abort_seen = abort_s;
endmodule // pcp_port
`default_nettype wire

// *** verification/pcp_port_sva.sv ***
// pin assertions for the parallel configuration port
`timescale 1ns/1ps
`default_nettype none
module pcp_port_sva (
	input wire logic	sys_clk,
	input wire logic	rst,
	input wire logic	full_reset_n,
	input wire logic [1:0]	mode_pins,
	input wire logic	port_select_n,
	input wire logic	read_write_dir,
	input wire logic	data_oe,
	input wire logic	init_oe,
	input wire logic	config_clock_oe,
	input wire logic	done,
	input wire logic	crc_error,
	input wire logic	abort_seen,
	input wire logic	chain_select_out_n,
	input wire logic	flash_write_enable_n
);
	// --------------------------------
	// pin relations
	// --------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst || !full_reset_n);
	chk_done_holds: assert property (done |=> done)
		else $error("done dropped");
	chk_done_clean: assert property (done |-> !crc_error)
		else $error("done with crc error");
	chk_init_cause: assert property (init_oe |-> crc_error)
		else $error("init pulled without crc error");
	chk_init_pull: assert property ($rose(crc_error) |-> ##[0:4] init_oe)
		else $error("crc error not shown on init");
	chk_bus_off: assert property (port_select_n [*4] |-> !data_oe)
		else $error("bus driven while deselected");
	chk_write_in: assert property (!read_write_dir [*4] |-> !data_oe)
		else $error("bus driven in write direction");
	chk_abort_stays: assert property (abort_seen && !port_select_n |=> abort_seen)
		else $error("abort lost while selected");
	chk_chain_low: assert property (done |-> !chain_select_out_n)
		else $error("chain select high after load");
	chk_slave_clk: assert property (mode_pins[1] [*4] |-> !config_clock_oe)
		else $error("clock driven in slave mode");
	chk_flash_we: assert property (flash_write_enable_n)
		else $error("flash write enable asserted");
	cover property (done);
	cover property (crc_error);
	cover property (abort_seen);
	cover property (config_clock_oe);
endmodule // pcp_port_sva
`default_nettype wire

// *** verification/pcp_host_model.sv ***
// behavioural slave host that clocks frames into the port
`timescale 1ns/1ps
`default_nettype none
module pcp_host_model (
	input wire logic	rst,
	input wire logic	go,
	input wire logic	rd_mode,
	input wire logic	flip_dir,
	input wire logic	hold_init,
	input wire logic	init_oe,
	input wire logic	init_out,
	input wire logic	data_oe,
	input wire logic [15:0]	data_out,
	input wire logic [15:0]	words [16],
	output logic	link_clk,
	output logic	port_select_n,
	output logic	read_write_dir,
	output logic [15:0]	data_in,
	output logic	init_in,
	output logic	frame_done
);
	// --------------------------------
	// wires and frames
	// --------------------------------
	logic	run;
	logic [15:0]	drive_q;
	// pull-up on init, either side may pull low
	assign init_in = (hold_init || (init_oe && !init_out)) ? 1'b0 : 1'b1;
	assign data_in = data_oe ? data_out : drive_q;
	// clock parks low outside frames, runs in reset so the link flops clear
	initial begin
		{link_clk, run, frame_done, read_write_dir, drive_q} = '0;
		port_select_n = 1'b1;
		#1;
		forever #3 if (run || rst || link_clk) link_clk = ~link_clk;
	end
	always @(posedge go) begin
		frame_done = 1'b0;
		read_write_dir = rd_mode;
		run = 1'b1;
		@(posedge link_clk);
		port_select_n <= 1'b0;
		repeat (2) @(posedge link_clk);
		for (int n = 0; n < 16; n++) begin
			drive_q <= words[n];
			if (flip_dir && n == 4) read_write_dir <= !rd_mode;
			@(posedge link_clk);
		end
		// stale data flips to its complement every edge, so a late capture shows up
		repeat (40) begin
			drive_q <= ~drive_q;
			@(posedge link_clk);
		end
		port_select_n <= 1'b1;
		repeat (4) @(posedge link_clk);
		read_write_dir <= 1'b0;
		run = 1'b0;
		frame_done = 1'b1;
	end
endmodule // pcp_host_model
`default_nettype wire

// *** verification/pcp_port_tb.sv ***
// self-checking bench for the parallel configuration port
`timescale 1ns/1ps
`default_nettype none
module pcp_port_tb;
	// --------------------------------
	// signals and helpers
	// --------------------------------
	logic	sys_clk, rst, full_reset_n, bus_x16, seu_detect_en, go, rd_mode, flip_dir, hold_init;
	logic [1:0]	mode_pins;
	logic	link_clk, port_select_n, read_write_dir, init_in, frame_done, seen, busy, busy_seen;
	logic	data_oe, init_out, init_oe, config_clock_oe, done, chain_select_out_n, abort_seen, crc_error;
	logic [15:0]	data_in, data_out;
	logic [15:0]	words [16];
	logic [31:0]	seed;
	int	bad_count, tests_run, i, k;
	int	cycles = 0;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
		for (int b = 15; b >= 0; b--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? 16'h1021 : 16'h0000);
		return c;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic restart(input logic [1:0] m);
		@(posedge sys_clk);
		rst <= 1'b1;
		hold_init <= 1'b1;
		mode_pins <= m;
		seed = xs(seed);
		seu_detect_en <= seed[0];
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk(done, 0);
		chk(config_clock_oe, 0);
		hold_init <= 1'b0;
		repeat (8) @(posedge sys_clk);
	endtask
	// last word carries the check value, residue is zero unless spoilt
	task automatic frame(input logic bad, input logic flip, input logic rd);
		logic [15:0] c;
		c = 16'hffff;
		for (k = 0; k < 15; k++) begin
			seed = xs(seed);
			words[k] = seed[15:0];
			c = crc_step(c, seed[15:0]);
		end
		words[15] = c ^ {15'h0000, bad};
		seen = 1'b0;
		busy_seen = 1'b0;
		rd_mode <= rd;
		flip_dir <= flip;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		for (k = 0; k < 400 && frame_done !== 1'b1; k++) begin
			@(posedge sys_clk);
			if (abort_seen === 1'b1) seen = 1'b1;
			if (busy === 1'b1) busy_seen = 1'b1;
			if (rd && k == 4) chk(data_oe, 1);
			// nothing was written, so readback shows the untouched check value
			if (rd && k == 4) chk(data_out, 16'hffff);
		end
		chk(busy_seen, !rd);
		repeat (10) @(posedge sys_clk);
		chk(done, !(bad || flip || rd));
		chk(data_oe, 0);
		chk(seen, flip);
		if (!flip) chk(crc_error, bad);
		if (!flip) chk(init_in, !bad);
		if (!(bad || flip || rd)) chk(chain_select_out_n, 0);
	endtask
	// --------------------------------
	// design, host and sequence
	// --------------------------------
	pcp_host_model u_pcp_host_model (.rst, .go, .rd_mode, .flip_dir, .hold_init, .init_oe, .init_out,
		.data_oe, .data_out, .words, .link_clk, .port_select_n, .read_write_dir, .data_in, .init_in,
		.frame_done);
	pcp_port u_pcp_port (.sys_clk, .rst, .link_clk, .full_reset_n, .mode_pins, .bus_x16, .seu_detect_en,
		.port_select_n, .read_write_dir, .data_in, .data_out, .data_oe, .init_in, .init_out, .init_oe,
		.config_clock_out(), .config_clock_oe, .done, .busy, .chain_select_out_n, .flash_addr(),
		.flash_output_enable_n(), .flash_chip_select_n(), .flash_write_enable_n(), .abort_seen, .crc_error);
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles > 4000) begin
			bad_count++;
			complete_run;
		end
	end
	initial begin
		{rst, full_reset_n, bus_x16, hold_init} = 4'hf;
		{seu_detect_en, go, rd_mode, flip_dir} = 4'h0;
		mode_pins = 2'h2;
		seed = 32'h4568;
		bad_count = 0;
		tests_run = 0;
		for (i = 0; i < 7; i++) begin
			restart(2'h2);
			frame(i == 1 || (i > 3 && seed[7]), i == 2, i == 3);
		end
		@(posedge sys_clk);
		full_reset_n <= 1'b0;
		#5;
		chk(done, 0);
		@(posedge sys_clk);
		full_reset_n <= 1'b1;
		restart(2'h0);
		chk(config_clock_oe, 1);
		complete_run;
	end
endmodule // pcp_port_tb
bind pcp_port pcp_port_sva u_pcp_port_sva (.sys_clk, .rst, .full_reset_n, .mode_pins, .port_select_n,
	.read_write_dir, .data_oe, .init_oe, .config_clock_oe, .done, .crc_error, .abort_seen,
	.chain_select_out_n, .flash_write_enable_n);
`default_nettype wire
